// ===== lcd_pkg.sv
// constants, command codes and carrier types for the lcd command decoder
`default_nettype none

package lcd_pkg;

  // ************************************************************
  // geometry and widths
  // ************************************************************
  localparam int          DATA_W      = 8;
  localparam int          PAGES       = 9;
  localparam int          COLS        = 132;
  localparam int          RAM_DEPTH   = PAGES * COLS;
  localparam int          ADDR_W      = 11;
  localparam int          FIFO_DEPTH  = 16;
  localparam logic [7:0]  COL_LAST    = 8'h83;

  // ************************************************************
  // timing
  // ************************************************************
  localparam int          CLK_PERIOD_NS = 10;
  localparam int          RESET_TIME_NS = 1000;
  localparam int          RESET_CYCLES  = (RESET_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ************************************************************
  // reset values
  // ************************************************************
  localparam logic [5:0]  VOLUME_RESET    = 6'h20;
  localparam logic [2:0]  RATIO_RESET     = 3'h0;
  localparam logic [2:0]  POWER_RESET     = 3'h0;
  localparam logic [1:0]  INDICATOR_RESET = 2'h0;
  localparam logic [5:0]  LINE_RESET      = 6'h00;
  localparam logic [3:0]  PAGE_RESET      = 4'h0;
  localparam logic [7:0]  COL_RESET       = 8'h00;

  // ************************************************************
  // status byte bit positions
  // ************************************************************
  localparam int          ST_BUSY  = 7;
  localparam int          ST_SEG   = 6;
  localparam int          ST_OFF   = 5;
  localparam int          ST_RESET = 4;

  // ************************************************************
  // command codes and match masks
  // ************************************************************
  localparam logic [7:0]  CMD_DISPLAY    = 8'hAE;
  localparam logic [7:0]  CMD_START_LINE = 8'h40;
  localparam logic [7:0]  CMD_PAGE       = 8'hB0;
  localparam logic [7:0]  CMD_COL_HIGH   = 8'h10;
  localparam logic [7:0]  CMD_COL_LOW    = 8'h00;
  localparam logic [7:0]  CMD_SEG_DIR    = 8'hA0;
  localparam logic [7:0]  CMD_REVERSE    = 8'hA6;
  localparam logic [7:0]  CMD_ALL_POINTS = 8'hA4;
  localparam logic [7:0]  CMD_BIAS       = 8'hA2;
  localparam logic [7:0]  CMD_RMW        = 8'hE0;
  localparam logic [7:0]  CMD_END        = 8'hEE;
  localparam logic [7:0]  CMD_RESET      = 8'hE2;
  localparam logic [7:0]  CMD_COM_SCAN   = 8'hC0;
  localparam logic [7:0]  CMD_POWER      = 8'h28;
  localparam logic [7:0]  CMD_RATIO      = 8'h20;
  localparam logic [7:0]  CMD_VOLUME     = 8'h81;
  localparam logic [7:0]  CMD_INDICATOR  = 8'hAC;
  localparam logic [7:0]  MASK_BIT0      = 8'hFE;
  localparam logic [7:0]  MASK_LOW3      = 8'hF8;
  localparam logic [7:0]  MASK_NIBBLE    = 8'hF0;
  localparam logic [7:0]  MASK_LINE      = 8'hC0;
  localparam logic [7:0]  MASK_EXACT     = 8'hFF;

  // ************************************************************
  // types
  // ************************************************************
  typedef struct packed {
    logic       isData;
    logic [7:0] value;
  } lcd_byte_t;

  typedef enum logic [1:0] {
    MODE_CMD       = 2'b00,
    MODE_VOLUME    = 2'b01,
    MODE_INDICATOR = 2'b10
  } lcd_mode_t;

endpackage

`default_nettype wire

// ===== lcd_cmd_decoder.sv
// lcd driver command decoder with its input fifo
`default_nettype none


// ************************************************************
// byte fifo
// ************************************************************
module lcd_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 16
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             ce,
  input  wire logic             inValid,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  inReady,
  output logic                  outValid,
  output logic      [WIDTH-1:0] outData,
  input  wire logic             outReady
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [0:DEPTH-1];
  logic [AW-1:0]    wrPtr_r;
  logic [AW-1:0]    rdPtr_r;
  logic [AW:0]      count_r;
  logic [AW:0]      count_nxt;
  logic             push;
  logic             pop;

  assign push    = inValid && inReady;
  assign pop     = outValid && outReady;
  assign outData = mem[rdPtr_r];

  always_comb begin
    count_nxt = count_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  end

  always_ff @(posedge clk) begin
    if (ce && push) begin
      mem[wrPtr_r] <= inData;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wrPtr_r  <= '0;
      rdPtr_r  <= '0;
      count_r  <= '0;
      inReady  <= 1'b1;
      outValid <= 1'b0;
    end else if (ce) begin
      if (push) begin
        wrPtr_r <= wrPtr_r + 1'b1;
      end
      if (pop) begin
        rdPtr_r <= rdPtr_r + 1'b1;
      end
      count_r  <= count_nxt;
      inReady  <= count_nxt < (AW+1)'(DEPTH);
      outValid <= count_nxt != '0;
    end
  end
endmodule

// ************************************************************
// command decoder top
// ************************************************************
module lcd_cmd_decoder (
  input  wire logic       core_clk,
  input  wire logic       rst,
  input  wire logic       ce,
  input  wire logic       hardware_reset_pin_n,
  input  wire logic       serialSelect,
  input  wire logic       command_data_select,
  input  wire logic       hostWrite,
  input  wire logic       hostRead,
  input  wire logic [7:0] hostData,
  input  wire logic       serialBitValid,
  input  wire logic       serialBit,
  input  wire logic [3:0] scanPage,
  input  wire logic [7:0] scanSeg,
  input  wire logic [2:0] scanBit,
  output logic            hostReady,
  output logic      [7:0] readData,
  output logic            readValid,
  output logic            busy,
  output logic            pixelLit,
  output logic            displayOn,
  output logic            segReverse,
  output logic            displayInvert,
  output logic            allPointsOn,
  output logic            powerSave,
  output logic            biasSeventh,
  output logic            comReverse,
  output logic      [2:0] resistorRatio,
  output logic      [2:0] powerControl,
  output logic      [5:0] volumeLevel,
  output logic      [1:0] indicatorMode,
  output logic            indicatorOn,
  output logic      [5:0] startLine,
  output logic            rmwActive
);

  // ************************************************************
  // declarations
  // ************************************************************
  logic [7:0]          ram [0:lcd_pkg::RAM_DEPTH-1];
  logic                hwReset;
  logic [6:0]          shift_r;
  logic [2:0]          bitCnt_r;
  logic                serialDone;
  logic                pushValid;
  lcd_pkg::lcd_byte_t  pushByte;
  lcd_pkg::lcd_byte_t  cur;
  logic                fifoValid;
  logic                exec;
  logic                isCmd;
  logic                resetCmd;
  logic                resetting_r;
  logic [7:0]          resetCnt_r;
  lcd_pkg::lcd_mode_t  mode_r;
  logic [3:0]          page_r;
  logic [7:0]          col_r;
  logic [7:0]          savedCol_r;
  logic [7:0]          readLatch_r;
  logic                readAccept;
  logic                statusAccept;
  logic                colAdvance;
  logic [7:0]          colInc;
  logic [10:0]         ramAddr;
  logic [7:0]          pixCol;
  logic [10:0]         pixAddr;
  logic [7:0]          pixByte;

  function automatic logic hit(input logic [7:0] b, input logic [7:0] code,
                               input logic [7:0] mask);
    hit = (b & mask) == code;
  endfunction

  // ************************************************************
  // reset and input capture
  // ************************************************************
  assign hwReset = rst || !hardware_reset_pin_n;

  // shift register, msb first
  always_ff @(posedge core_clk) begin
    if (hwReset) begin
      shift_r  <= 7'h00;
      bitCnt_r <= 3'h0;
    end else if (ce && serialSelect && serialBitValid) begin
      shift_r  <= {shift_r[5:0], serialBit};
      bitCnt_r <= bitCnt_r + 3'h1;
    end
  end

  assign serialDone = serialSelect && serialBitValid && (bitCnt_r == 3'h7);

  // writes offered while reset runs are dropped at the port
  assign pushValid = (serialSelect ? serialDone : hostWrite) && !resetting_r;
  assign pushByte.isData = command_data_select;
  assign pushByte.value  = serialSelect ? {shift_r, serialBit} : hostData;

  lcd_fifo #(
    .WIDTH ($bits(lcd_pkg::lcd_byte_t)),
    .DEPTH (lcd_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk      (core_clk),
    .rst      (hwReset),
    .ce       (ce),
    .inValid  (pushValid),
    .inData   (pushByte),
    .inReady  (hostReady),
    .outValid (fifoValid),
    .outData  (cur),
    .outReady (!resetting_r)
  );

  assign exec     = fifoValid && !resetting_r;
  assign isCmd    = exec && !cur.isData && (mode_r == lcd_pkg::MODE_CMD);
  assign resetCmd = isCmd && hit(cur.value, lcd_pkg::CMD_RESET, lcd_pkg::MASK_EXACT);

  // ************************************************************
  // initialisation timer
  // ************************************************************
  always_ff @(posedge core_clk) begin
    if (hwReset) begin
      resetCnt_r  <= 8'(lcd_pkg::RESET_CYCLES);
      resetting_r <= 1'b1;
    end else if (ce) begin
      if (resetCmd) begin
        resetCnt_r  <= 8'(lcd_pkg::RESET_CYCLES);
        resetting_r <= 1'b1;
      end else if (resetCnt_r != 8'h00) begin
        resetCnt_r  <= resetCnt_r - 8'h01;
        resetting_r <= resetCnt_r > 8'h01;
      end
    end
  end

  // ************************************************************
  // command modes and two byte commands
  // ************************************************************
  always_ff @(posedge core_clk) begin
    if (hwReset) begin
      mode_r        <= lcd_pkg::MODE_CMD;
      volumeLevel   <= lcd_pkg::VOLUME_RESET;
      indicatorMode <= lcd_pkg::INDICATOR_RESET;
      indicatorOn   <= 1'b0;
    end else if (ce) begin
      if (resetCmd) begin
        volumeLevel   <= lcd_pkg::VOLUME_RESET;
        indicatorMode <= lcd_pkg::INDICATOR_RESET;
        indicatorOn   <= 1'b0;
      end else if (exec && !cur.isData) begin
        case (mode_r)
          lcd_pkg::MODE_VOLUME: begin
            volumeLevel <= cur.value[5:0];
            mode_r      <= lcd_pkg::MODE_CMD;
          end
          lcd_pkg::MODE_INDICATOR: begin
            indicatorMode <= cur.value[1:0];
            mode_r        <= lcd_pkg::MODE_CMD;
          end
          default: begin
            if (hit(cur.value, lcd_pkg::CMD_VOLUME, lcd_pkg::MASK_EXACT)) begin
              mode_r <= lcd_pkg::MODE_VOLUME;
            end else if (hit(cur.value, lcd_pkg::CMD_INDICATOR, lcd_pkg::MASK_BIT0)) begin
              indicatorOn <= cur.value[0];
              if (cur.value[0]) begin
                mode_r <= lcd_pkg::MODE_INDICATOR;
              end
            end
          end
        endcase
      end
    end
  end

  // ************************************************************
  // display configuration
  // ************************************************************
  always_ff @(posedge core_clk) begin
    if (hwReset) begin
      displayOn     <= 1'b0;
      segReverse    <= 1'b0;
      displayInvert <= 1'b0;
      allPointsOn   <= 1'b0;
      biasSeventh   <= 1'b0;
      powerControl  <= lcd_pkg::POWER_RESET;
    end else if (ce && isCmd) begin
      if (hit(cur.value, lcd_pkg::CMD_DISPLAY, lcd_pkg::MASK_BIT0)) begin
        displayOn <= cur.value[0];
      end
      if (hit(cur.value, lcd_pkg::CMD_SEG_DIR, lcd_pkg::MASK_BIT0)) begin
        segReverse <= cur.value[0];
      end
      if (hit(cur.value, lcd_pkg::CMD_REVERSE, lcd_pkg::MASK_BIT0)) begin
        displayInvert <= cur.value[0];
      end
      if (hit(cur.value, lcd_pkg::CMD_ALL_POINTS, lcd_pkg::MASK_BIT0)) begin
        allPointsOn <= cur.value[0];
      end
      if (hit(cur.value, lcd_pkg::CMD_BIAS, lcd_pkg::MASK_BIT0)) begin
        biasSeventh <= cur.value[0];
      end
      if (hit(cur.value, lcd_pkg::CMD_POWER, lcd_pkg::MASK_LOW3)) begin
        powerControl <= cur.value[2:0];
      end
    end
  end

  // items that the reset command also restores
  always_ff @(posedge core_clk) begin
    if (hwReset || (ce && resetCmd)) begin
      startLine     <= lcd_pkg::LINE_RESET;
      comReverse    <= 1'b0;
      resistorRatio <= lcd_pkg::RATIO_RESET;
    end else if (ce && isCmd) begin
      if (hit(cur.value, lcd_pkg::CMD_START_LINE, lcd_pkg::MASK_LINE)) begin
        startLine <= cur.value[5:0];
      end
      if (hit(cur.value, lcd_pkg::CMD_COM_SCAN, lcd_pkg::MASK_NIBBLE)) begin
        comReverse <= cur.value[3];
      end
      if (hit(cur.value, lcd_pkg::CMD_RATIO, lcd_pkg::MASK_LOW3)) begin
        resistorRatio <= cur.value[2:0];
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (hwReset) begin
      powerSave <= 1'b0;
    end else if (ce) begin
      powerSave <= allPointsOn && !displayOn;
    end
  end

  // ************************************************************
  // address counters and read modify write
  // ************************************************************
  assign ramAddr    = 11'(page_r) * 11'(lcd_pkg::COLS) + 11'(col_r);
  assign readAccept = ce && hostRead && !serialSelect && command_data_select
                      && !fifoValid && !resetting_r;
  assign statusAccept = ce && hostRead && !serialSelect && !command_data_select;
  assign colAdvance = (exec && cur.isData) || (readAccept && !rmwActive);
  assign colInc     = (col_r == lcd_pkg::COL_LAST) ? col_r : col_r + 8'h01;

  always_ff @(posedge core_clk) begin
    if (hwReset || (ce && resetCmd)) begin
      page_r     <= lcd_pkg::PAGE_RESET;
      col_r      <= lcd_pkg::COL_RESET;
      savedCol_r <= lcd_pkg::COL_RESET;
      rmwActive  <= 1'b0;
    end else if (ce) begin
      if (isCmd && hit(cur.value, lcd_pkg::CMD_PAGE, lcd_pkg::MASK_NIBBLE)) begin
        page_r <= cur.value[3:0];
      end
      if (isCmd && hit(cur.value, lcd_pkg::CMD_COL_HIGH, lcd_pkg::MASK_NIBBLE)) begin
        col_r[7:4] <= cur.value[3:0];
      end else if (isCmd && hit(cur.value, lcd_pkg::CMD_COL_LOW, lcd_pkg::MASK_NIBBLE)) begin
        col_r[3:0] <= cur.value[3:0];
      end else if (isCmd && rmwActive
                   && hit(cur.value, lcd_pkg::CMD_END, lcd_pkg::MASK_EXACT)) begin
        col_r     <= savedCol_r;
        rmwActive <= 1'b0;
      end else if (isCmd && hit(cur.value, lcd_pkg::CMD_RMW, lcd_pkg::MASK_EXACT)) begin
        savedCol_r <= col_r;
        rmwActive  <= 1'b1;
      end else if (colAdvance) begin
        col_r <= colInc;
      end
    end
  end

  // ************************************************************
  // display ram
  // ************************************************************
  always_ff @(posedge core_clk) begin
    if (ce && exec && cur.isData) begin
      ram[ramAddr] <= cur.value;
    end
  end

  // pipelined read: each read hands back the byte fetched by the one before
  always_ff @(posedge core_clk) begin
    if (hwReset) begin
      readLatch_r <= 8'h00;
    end else if (readAccept) begin
      readLatch_r <= ram[ramAddr];
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      readData  <= 8'h00;
      readValid <= 1'b0;
      busy      <= 1'b1;
    end else if (ce) begin
      busy      <= resetting_r || fifoValid;
      readValid <= readAccept || statusAccept;
      if (readAccept) begin
        readData <= readLatch_r;
      end else if (statusAccept) begin
        readData                    <= 8'h00;
        readData[lcd_pkg::ST_BUSY]  <= busy;
        readData[lcd_pkg::ST_SEG]   <= !segReverse;
        readData[lcd_pkg::ST_OFF]   <= !displayOn;
        readData[lcd_pkg::ST_RESET] <= resetting_r;
      end
    end
  end

  // ************************************************************
  // pixel output path
  // ************************************************************
  assign pixCol  = segReverse ? (lcd_pkg::COL_LAST - scanSeg) : scanSeg;
  assign pixAddr = 11'(scanPage) * 11'(lcd_pkg::COLS) + 11'(pixCol);
  assign pixByte = ram[pixAddr];

  always_ff @(posedge core_clk) begin
    if (hwReset) begin
      pixelLit <= 1'b0;
    end else if (ce) begin
      pixelLit <= displayOn && !powerSave
                  && (allPointsOn || (pixByte[scanBit] ^ displayInvert));
    end
  end

endmodule

`default_nettype wire

// ===== lcd_host_model.sv
// host processor model driving the decoder's parallel and serial inputs
`default_nettype none

module lcd_host_model (
  input  wire logic       core_clk,
  input  wire logic       hostReady,
  input  wire logic [7:0] readData,
  input  wire logic       readValid,
  output logic            command_data_select,
  output logic            hostWrite,
  output logic            hostRead,
  output logic      [7:0] hostData,
  output logic            serialBitValid,
  output logic            serialBit
);
  timeunit 1ns;
  timeprecision 1ps;

  // ************************************************************
  // idle levels
  // ************************************************************
  initial begin
    command_data_select = 1'b0;
    hostWrite = 1'b0;
    hostRead = 1'b0;
    hostData = 8'hFF;
    serialBitValid = 1'b0;
    serialBit = 1'b1;
  end

  // ************************************************************
  // transfers
  // ************************************************************
  // one parallel byte, spaced so the fifo is empty again on return
  task automatic put_byte(input logic cds, input logic [7:0] value);
    while (hostReady !== 1'b1) @(posedge core_clk);
    @(posedge core_clk);
    hostWrite <= 1'b1;
    command_data_select <= cds;
    hostData <= value;
    @(posedge core_clk);
    hostWrite <= 1'b0;
    hostData <= ~value;
    repeat (3) @(posedge core_clk);
    #1;
  endtask

  // one read pulse; value stays unknown when no answer comes
  task automatic get_byte(input logic cds, output logic [7:0] value);
    value = 8'hXX;
    @(posedge core_clk);
    hostRead <= 1'b1;
    command_data_select <= cds;
    @(posedge core_clk);
    hostRead <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      #1;
      if (readValid === 1'b1) begin
        value = readData;
        break;
      end
      @(posedge core_clk);
    end
  endtask

  // serial byte, most significant bit first
  task automatic shift_byte(input logic cds, input logic [7:0] value);
    for (int i = 7; i >= 0; i--) begin
      @(posedge core_clk);
      serialBitValid <= 1'b1;
      serialBit <= value[i];
      command_data_select <= cds;
      @(posedge core_clk);
      serialBitValid <= 1'b0;
      serialBit <= ~value[i];
    end
    repeat (3) @(posedge core_clk);
    #1;
  endtask
endmodule

`default_nettype wire

// ===== lcd_cmd_checker.sv
// concurrent checks on the command decoder's ports
`default_nettype none

module lcd_cmd_checker (
  input wire logic       core_clk,
  input wire logic       rst,
  input wire logic       ce,
  input wire logic       hardware_reset_pin_n,
  input wire logic       serialSelect,
  input wire logic       command_data_select,
  input wire logic       hostWrite,
  input wire logic       hostRead,
  input wire logic [7:0] hostData,
  input wire logic       hostReady,
  input wire logic [7:0] readData,
  input wire logic       readValid,
  input wire logic       busy,
  input wire logic       displayOn,
  input wire logic       segReverse,
  input wire logic       allPointsOn,
  input wire logic       powerSave,
  input wire logic       comReverse,
  input wire logic [2:0] resistorRatio,
  input wire logic       rmwActive
);
  timeunit 1ns;
  timeprecision 1ps;

  logic cmdTaken;
  logic statusRead;
  assign cmdTaken = hostWrite && hostReady && !busy && ce && hardware_reset_pin_n
                    && !serialSelect && !command_data_select;
  assign statusRead = hostRead && ce && !serialSelect && !command_data_select;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  // ************************************************************
  // sequences
  // ************************************************************
  sequence s_cmd(logic [7:0] m, logic [7:0] c);
    cmdTaken && ((hostData & m) == c);
  endsequence
  sequence s_init_busy;
    busy [*8];
  endsequence

  // ************************************************************
  // properties
  // ************************************************************
  property p_status_nibble;
    statusRead |=> readValid && readData[3:0] == 4'h0;
  endproperty
  property p_status_flags;
    statusRead |=> readData[6:5] == {!$past(segReverse), !$past(displayOn)};
  endproperty
  property p_serial_no_read;
    hostRead && serialSelect && ce |=> !readValid;
  endproperty
  property p_init_busy;
    $past(rst) |-> s_init_busy;
  endproperty
  property p_power_save;
    (allPointsOn && !displayOn && hardware_reset_pin_n && ce) [*2] |-> powerSave;
  endproperty
  property p_seg_dir;
    s_cmd(8'hFE, 8'hA0) |-> ##2 segReverse == $past(hostData[0], 2);
  endproperty
  property p_com_scan;
    s_cmd(8'hF0, 8'hC0) |-> ##2 comReverse == $past(hostData[3], 2);
  endproperty
  property p_ratio;
    s_cmd(8'hF8, 8'h20) |-> ##2 resistorRatio == $past(hostData[2:0], 2);
  endproperty
  property p_rmw_enter;
    s_cmd(8'hFF, 8'hE0) |-> ##2 rmwActive;
  endproperty
  property p_rmw_end;
    s_cmd(8'hFF, 8'hEE) |-> ##2 !rmwActive;
  endproperty
  property p_reset_cmd;
    s_cmd(8'hFF, 8'hE2) |-> ##3 busy [*4] ##100 (!rmwActive && resistorRatio == 3'h0);
  endproperty

  a_status_nibble : assert property (p_status_nibble) else $error("status low nibble");
  a_status_flags : assert property (p_status_flags) else $error("status flags");
  a_serial_no_read : assert property (p_serial_no_read) else $error("serial read");
  a_init_busy : assert property (p_init_busy) else $error("busy after reset");
  a_power_save : assert property (p_power_save) else $error("power save");
  a_seg_dir : assert property (p_seg_dir) else $error("segment direction");
  a_com_scan : assert property (p_com_scan) else $error("common scan");
  a_ratio : assert property (p_ratio) else $error("resistor ratio");
  a_rmw_enter : assert property (p_rmw_enter) else $error("rmw entry");
  a_rmw_end : assert property (p_rmw_end) else $error("rmw end");
  a_reset_cmd : assert property (p_reset_cmd) else $error("reset command");
endmodule

bind lcd_cmd_decoder lcd_cmd_checker u_checker (
  .core_clk, .rst, .ce, .hardware_reset_pin_n, .serialSelect, .command_data_select,
  .hostWrite, .hostRead, .hostData, .hostReady, .readData, .readValid, .busy,
  .displayOn, .segReverse, .allPointsOn, .powerSave, .comReverse, .resistorRatio,
  .rmwActive
);

`default_nettype wire

// ===== tb_lcd_cmd_decoder.sv
// self-checking testbench for the lcd command decoder
`default_nettype none

module tb_lcd_cmd_decoder;
  timeunit 1ns;
  timeprecision 1ps;

  logic       core_clk, rst, ce, hardware_reset_pin_n, serialSelect;
  logic       cds, hostWrite, hostRead, serialBitValid, serialBit;
  logic [7:0] hostData, readData, scanSeg, got;
  logic [3:0] scanPage;
  logic [2:0] scanBit, resistorRatio, powerControl;
  logic       hostReady, readValid, busy, pixelLit, displayOn, segReverse, displayInvert;
  logic       allPointsOn, powerSave, biasSeventh, comReverse, rmwActive;
  logic [5:0] volumeLevel, startLine;
  logic [1:0] indicatorMode;
  logic       indicatorOn;
  int         n_mismatch, check_count, cycles;
  logic [7:0] setup [6] = '{8'hAF, 8'hA1, 8'hA3, 8'hC8, 8'h25, 8'h2F};

  lcd_host_model host (.core_clk, .hostReady, .readData, .readValid,
    .command_data_select(cds), .hostWrite, .hostRead, .hostData, .serialBitValid, .serialBit);

  lcd_cmd_decoder DUT (.core_clk, .rst, .ce, .hardware_reset_pin_n, .serialSelect,
    .command_data_select(cds), .hostWrite, .hostRead, .hostData, .serialBitValid,
    .serialBit, .scanPage, .scanSeg, .scanBit, .hostReady, .readData, .readValid, .busy,
    .pixelLit, .displayOn, .segReverse, .displayInvert, .allPointsOn, .powerSave,
    .biasSeventh, .comReverse, .resistorRatio, .powerControl, .volumeLevel,
    .indicatorMode, .indicatorOn, .startLine, .rmwActive);

  // ************************************************************
  // helpers
  // ************************************************************
  always #5 core_clk = ~core_clk;

  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 5000) begin
      n_mismatch++;
      complete_run();
    end
  end

  task automatic check8(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic complete_run();
    $display("mismatches %0d comparisons %0d", n_mismatch, check_count);
    if (n_mismatch == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic cmd(input logic [7:0] v);
    host.put_byte(1'b0, v);
  endtask
  task automatic dat(input logic [7:0] v);
    host.put_byte(1'b1, v);
  endtask
  task automatic set_col(input logic [7:0] c);
    cmd({4'h1, c[7:4]});
    cmd({4'h0, c[3:0]});
  endtask
  task automatic wait_init();
    repeat (lcd_pkg::RESET_CYCLES + 10) @(posedge core_clk);
    #1;
  endtask

  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    core_clk = 1'b0;
    rst = 1'b1;
    ce = 1'b1;
    hardware_reset_pin_n = 1'b1;
    serialSelect = 1'b0;
    scanPage = 4'h0;
    scanSeg = 8'h00;
    scanBit = 3'h0;
    repeat (5) @(posedge core_clk);
    rst <= 1'b0;
    host.get_byte(1'b0, got);
    check8(got, 8'hF0);
    wait_init();
    host.get_byte(1'b0, got);
    check8(got, 8'h60);
    foreach (setup[i]) cmd(setup[i]);
    check8({displayOn, segReverse, biasSeventh, comReverse, 1'b0, resistorRatio}, 8'hF5);
    check8({5'h00, powerControl}, 8'h07);
    host.get_byte(1'b0, got);
    check8(got, 8'h00);
    cmd(8'hB1);
    set_col(8'h00);
    dat(8'h55);
    dat(8'hAA);
    set_col(8'h00);
    host.get_byte(1'b1, got);
    host.get_byte(1'b1, got);
    check8(got, 8'h55);
    host.get_byte(1'b1, got);
    check8(got, 8'hAA);
    set_col(8'h01);
    cmd(8'hE0);
    host.get_byte(1'b1, got);
    host.get_byte(1'b1, got);
    host.get_byte(1'b1, got);
    check8({got[7:1], rmwActive}, 8'hAB);
    dat(8'h33);
    dat(8'h44);
    cmd(8'hEE);
    host.get_byte(1'b1, got);
    host.get_byte(1'b1, got);
    check8({got[7:1], rmwActive}, 8'h32);
    set_col(8'h83);
    dat(8'h77);
    dat(8'h66);
    set_col(8'h83);
    host.get_byte(1'b1, got);
    host.get_byte(1'b1, got);
    check8(got, 8'h66);
    host.get_byte(1'b1, got);
    check8(got, 8'h66);
    cmd(8'hA7);
    cmd(8'hA5);
    @(posedge core_clk);
    #1;
    check8({5'h00, displayInvert, allPointsOn, pixelLit}, 8'h07);
    cmd(8'hAE);
    check8({7'h00, powerSave}, 8'h01);
    host.get_byte(1'b0, got);
    check8(got, 8'h20);
    cmd(8'h81);
    cmd(8'h15);
    cmd(8'hAD);
    cmd(8'h02);
    cmd(8'h45);
    check8({2'h0, volumeLevel}, 8'h15);
    check8({indicatorOn, 5'h00, indicatorMode}, 8'h82);
    check8({2'h0, startLine}, 8'h05);
    cmd(8'hE2);
    host.get_byte(1'b0, got);
    check8(got, 8'hB0);
    wait_init();
    check8({comReverse, biasSeventh, 3'h0, resistorRatio}, 8'h40);
    check8({volumeLevel, indicatorMode}, 8'h80);
    check8({indicatorOn, 1'b0, startLine}, 8'h00);
    check8({5'h00, powerControl}, 8'h07);
    cmd(8'hB1);
    set_col(8'h00);
    host.get_byte(1'b1, got);
    host.get_byte(1'b1, got);
    check8(got, 8'h55);
    @(posedge core_clk);
    serialSelect <= 1'b1;
    host.shift_byte(1'b0, 8'hA0);
    check8({7'h00, segReverse}, 8'h00);
    host.get_byte(1'b1, got);
    check8(got, 8'hXX);
    serialSelect <= 1'b0;
    hardware_reset_pin_n <= 1'b0;
    repeat (3) @(posedge core_clk);
    hardware_reset_pin_n <= 1'b1;
    wait_init();
    check8({displayOn, biasSeventh, allPointsOn, powerSave, 1'b0, powerControl}, 8'h00);
    complete_run();
  end
endmodule

`default_nettype wire
